// ==== core/mda_pkg.sv ====
package mda_pkg;
    // sizes of the channel set and descriptor pool
    localparam int NUM_CH = 24;
    localparam int NUM_TD = 128;
    localparam int TD_WORDS = 2 * NUM_TD;
    // register byte offsets on the wishbone port
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_SWTRIG = 12'h004;
    localparam logic [11:0] REG_STALL = 12'h008;
    localparam logic [11:0] REG_CANCEL = 12'h00c;
    localparam logic [11:0] REG_BUSY = 12'h010;
    localparam logic [11:0] REG_ACTIVE = 12'h014;
    // channel config page 0x080..0x0dc, selected by adr[11:7]
    localparam logic [4:0] REG_CFG_PAGE = 5'h01;
    // descriptor page 0x400..0x7fc, selected by adr[11:10]
    localparam logic [1:0] REG_TD_PAGE = 2'h1;
    // values after reset
    localparam logic [17:0] CFG_RST = 18'h00000;
    localparam logic FAIR_RST = 1'b0;
    // channel config fields
    localparam int CFG_PRIO = 0;
    localparam int CFG_RRDIS = 3;
    localparam int CFG_FIRST = 4;
    localparam int CFG_EN = 11;
    localparam int CFG_CHSRC = 12;
    localparam int CFG_CHEN = 17;
    // descriptor word 0 fields
    localparam int TD_SRC = 0;
    localparam int TD_DST = 16;
    // descriptor word 1 fields
    localparam int TD_CNT = 0;
    localparam int TD_NEXT = 16;
    localparam int TD_NEXTV = 23;
    localparam int TD_INF = 24;
    localparam int TD_SRCINC = 25;
    localparam int TD_DSTINC = 26;
    localparam int TD_INTEACH = 27;
    localparam int TD_INTEND = 28;
    // hub window 0xf000..0xf3ff that maps dma writes (destination only) onto descriptor storage
    localparam logic [5:0] TD_WIN = 6'h3c;
    // contests the cpu may win in a row while the dma waits
    localparam logic [2:0] STARVE_LIM = 3'h4;
    localparam logic [23:0] CH_ONE = 24'h000001;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOAD, ST_READ, ST_WRITE, ST_FIN
    } mda_state_t;
endpackage

// ==== core/mda_core.sv ====
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module mda_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // wishbone register port
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // routed channel requests
    input wire logic [23:0] dmaReq,
    // hub sharing with the cpu
    input wire logic cpuReq,
    output logic cpuGnt,
    // hub master port
    output logic hubCyc,
    output logic hubWe,
    output logic [15:0] hubAddr,
    output logic [7:0] hubWdata,
    input wire logic [7:0] hubRdata,
    input wire logic hubAck,
    // channel interrupt pulses
    output logic [23:0] chIntA,
    output logic [23:0] chIntB
);
    // byte lanes of a write folded into a word
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    // level favoured by the slot counter: level 2 every other slot, etc.
    function automatic logic [2:0] favLvl(input logic [5:0] slot);
        logic [2:0] low;
        low = 3'h5;
        for (int b = 5; b >= 0; b--) begin
            if (slot[b]) begin
                low = 3'(b);
            end
        end
        return 3'(low + 3'h2);
    endfunction

    // arbitration: returns {hit, level, channel}
    function automatic logic [8:0] pick(input logic [23:0] req,
            input logic [23:0][2:0] prio, input logic [23:0] rrDis,
            input logic [7:0][4:0] last, input logic fair,
            input logic [5:0] slot);
        logic [7:0] hit;
        logic [2:0] lvl;
        logic [2:0] fav;
        logic [4:0] ch;
        logic fix;
        int j;
        hit = 8'h00;
        lvl = 3'h7;
        ch = 5'h00;
        fix = 1'b0;
        j = 0;
        fav = favLvl(slot);
        for (int i = 0; i < 24; i++) begin
            if (req[i]) begin
                hit[prio[i]] = 1'b1;
            end
        end
        for (int l = 7; l >= 0; l--) begin
            if (hit[l]) begin
                lvl = 3'(l);
            end
        end
        // fair slot only when levels 0 and 1 are quiet
        if (fair && !hit[0] && !hit[1] && hit[fav]) begin
            lvl = fav;
        end
        for (int i = 23; i >= 0; i--) begin
            if (req[i] && prio[i] == lvl && rrDis[i]) begin
                fix = 1'b1;
                ch = 5'(i);
            end
        end
        if (!fix) begin
            for (int k = 24; k >= 1; k--) begin
                j = (int'(last[lvl]) + k) % 24;
                if (req[j] && prio[j] == lvl) begin
                    ch = 5'(j);
                end
            end
        end
        return {|req, lvl, ch};
    endfunction

    mda_pkg::mda_state_t stateReg;
    logic wbAckReg;
    logic [31:0] wbDatReg;
    logic fairEnReg;
    logic [23:0] stallReg, busyReg, needLoadReg, cancelPendReg;
    logic [17:0] chCfgReg [mda_pkg::NUM_CH];
    logic [31:0] tdMem [mda_pkg::TD_WORDS];
    logic [6:0] chTdReg [mda_pkg::NUM_CH];
    logic [15:0] chSrcReg [mda_pkg::NUM_CH];
    logic [15:0] chDstReg [mda_pkg::NUM_CH];
    logic [15:0] chCntReg [mda_pkg::NUM_CH];
    logic [4:0] curChReg;
    logic [7:0][4:0] rrLastReg;
    logic [5:0] slotReg;
    logic [2:0] starveReg;
    logic [7:0] dataReg;
    logic hubCycReg, hubWeReg, cpuGntReg;
    logic [15:0] hubAddrReg;
    logic [7:0] hubWdataReg;
    logic [23:0] chIntAReg, chIntBReg;
    logic donePReg;
    logic [4:0] doneChReg;

    // wishbone decode
    wire wbHit = wb_cyc_i & wb_stb_i & ~wbAckReg;
    wire wbWr = wbHit & wb_we_i;
    wire isTd = wb_adr_i[11:10] == mda_pkg::REG_TD_PAGE;
    wire [7:0] tdIdx = wb_adr_i[9:2];
    wire [4:0] cfgIdx = wb_adr_i[6:2];
    wire isCfg = (wb_adr_i[11:7] == mda_pkg::REG_CFG_PAGE) && (cfgIdx < 5'd24);
    wire tdWbWr = wbWr & isTd;
    wire [31:0] wmask = merge(32'h0, 32'hffffffff, wb_sel_i);
    wire [23:0] swTrig = (wbWr && wb_adr_i == mda_pkg::REG_SWTRIG) ?
        (wb_dat_i[23:0] & wmask[23:0]) : 24'h0;
    wire [23:0] cancelW = (wbWr && wb_adr_i == mda_pkg::REG_CANCEL) ?
        (wb_dat_i[23:0] & wmask[23:0]) : 24'h0;

    // read mux; unmapped offsets answer zero
    wire [31:0] rdData =
        isTd ? tdMem[tdIdx] :
        isCfg ? {14'h0, chCfgReg[cfgIdx]} :
        (wb_adr_i == mda_pkg::REG_CTRL) ? {31'h0, fairEnReg} :
        (wb_adr_i == mda_pkg::REG_STALL) ? {8'h0, stallReg} :
        (wb_adr_i == mda_pkg::REG_BUSY) ? {8'h0, busyReg} :
        (wb_adr_i == mda_pkg::REG_ACTIVE) ?
            {23'h0, stateReg != mda_pkg::ST_IDLE, 3'h0, curChReg} : 32'h0;

    // current channel context and its descriptor, read live from storage
    wire [6:0] curTd = chTdReg[curChReg];
    wire [31:0] w0 = tdMem[{curTd, 1'b0}];
    wire [31:0] w1 = tdMem[{curTd, 1'b1}];
    wire [15:0] curSrc = chSrcReg[curChReg];
    wire [15:0] curDst = chDstReg[curChReg];
    wire [15:0] curCnt = chCntReg[curChReg];
    wire dstInt = curDst[15:10] == mda_pkg::TD_WIN;
    wire atFin = stateReg == mda_pkg::ST_FIN;
    wire lastBeat = (curCnt == 16'h0) & ~w1[mda_pkg::TD_INF];
    wire finDone = atFin & lastBeat;
    wire hasNext = w1[mda_pkg::TD_NEXTV];
    wire [23:0] finMask = mda_pkg::CH_ONE << curChReg;
    wire [23:0] curMask = (stateReg != mda_pkg::ST_IDLE) ? finMask : 24'h0;

    // channel start, cancel and request masks
    logic [23:0] trig, rrDisV;
    logic [23:0][2:0] prioV;
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            prioV[i] = chCfgReg[i][mda_pkg::CFG_PRIO +: 3];
            rrDisV[i] = chCfgReg[i][mda_pkg::CFG_RRDIS];
            trig[i] = chCfgReg[i][mda_pkg::CFG_EN] & (dmaReq[i] | swTrig[i] |
                (donePReg & chCfgReg[i][mda_pkg::CFG_CHEN] &
                (chCfgReg[i][mda_pkg::CFG_CHSRC +: 5] == doneChReg)));
        end
    end
    wire [23:0] newStart = trig & ~busyReg;
    wire [23:0] killNow = (cancelPendReg | cancelW) & ~curMask;
    wire [23:0] endMask = (finDone && !hasNext) ? finMask : 24'h0;
    wire [23:0] chainMask = (finDone && hasNext) ? finMask : 24'h0;
    wire [23:0] loadMask = (stateReg == mda_pkg::ST_LOAD) ? finMask : 24'h0;
    // a start in the same cycle as a cancel keeps the channel running
    wire [23:0] busyNext = (busyReg & ~killNow & ~endMask) | newStart;
    wire [23:0] reqMask = busyReg & ~stallReg & ~cancelPendReg & ~cancelW;

    wire [8:0] pk = pick(reqMask, prioV, rrDisV, rrLastReg, fairEnReg,
        slotReg);
    wire grantFire = (stateReg == mda_pkg::ST_IDLE) & pk[8];
    wire [2:0] pickLvl = pk[7:5];
    wire [4:0] pickCh = pk[4:0];

    // hub contest: cpu first unless the dma has waited its limit
    wire dmaWants = ((stateReg == mda_pkg::ST_READ) |
        ((stateReg == mda_pkg::ST_WRITE) & ~dstInt)) & ~hubCycReg;
    wire cpuWin = cpuReq & ~hubCycReg &
        ~(dmaWants & (starveReg == mda_pkg::STARVE_LIM));
    wire hubStart = dmaWants & ~cpuWin;
    wire hubEnd = hubCycReg & hubAck;
    wire tdDmaWr = (stateReg == mda_pkg::ST_WRITE) & dstInt & ~tdWbWr;
    wire [3:0] laneSel = 4'(4'h1 << curDst[1:0]);
    // byte-lane merges for the registers that honour sel
    wire [31:0] stallMerged = merge({8'h0, stallReg}, wb_dat_i, wb_sel_i);
    wire [31:0] cfgMerged = merge({14'h0, chCfgReg[cfgIdx]}, wb_dat_i,
        wb_sel_i);

    // wishbone answer and global controls; ack one cycle after strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wbAckReg <= 1'b0;
            wbDatReg <= 32'h0;
            fairEnReg <= mda_pkg::FAIR_RST;
            stallReg <= 24'h0;
        end else begin
            wbAckReg <= wbHit;
            wbDatReg <= rdData;
            if (wbWr && wb_adr_i == mda_pkg::REG_CTRL && wb_sel_i[0]) begin
                fairEnReg <= wb_dat_i[0];
            end
            if (wbWr && wb_adr_i == mda_pkg::REG_STALL) begin
                stallReg <= stallMerged[23:0];
            end
        end
    end

    // channel configuration words
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 24; i++) begin
                chCfgReg[i] <= mda_pkg::CFG_RST;
            end
        end else if (wbWr && isCfg) begin
            chCfgReg[cfgIdx] <= cfgMerged[17:0];
        end
    end

    // descriptor storage: software wins a clash, the engine then waits
    always_ff @(posedge sys_clk) begin
        if (tdWbWr) begin
            tdMem[tdIdx] <= merge(tdMem[tdIdx], wb_dat_i, wb_sel_i);
        end else if (tdDmaWr) begin
            tdMem[curDst[9:2]] <= merge(tdMem[curDst[9:2]], {4{dataReg}},
                laneSel);
        end
    end

    // engine: one byte moves per grant, so preemption falls between bytes
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stateReg <= mda_pkg::ST_IDLE;
            curChReg <= 5'h00;
            rrLastReg <= '0;
            slotReg <= 6'h00;
            dataReg <= 8'h00;
        end else begin
            unique case (stateReg)
                mda_pkg::ST_IDLE: begin
                    if (pk[8]) begin
                        curChReg <= pickCh;
                        rrLastReg[pickLvl] <= pickCh;
                        if (fairEnReg && pickLvl >= 3'h2) begin
                            slotReg <= 6'(slotReg + 6'h01);
                        end
                        stateReg <= needLoadReg[pickCh] ?
                            mda_pkg::ST_LOAD : mda_pkg::ST_READ;
                    end
                end
                mda_pkg::ST_LOAD: begin
                    stateReg <= mda_pkg::ST_READ;
                end
                mda_pkg::ST_READ: begin
                    if (hubEnd) begin
                        dataReg <= hubRdata;
                        stateReg <= mda_pkg::ST_WRITE;
                    end
                end
                mda_pkg::ST_WRITE: begin
                    if (dstInt ? !tdWbWr : hubEnd) begin
                        stateReg <= mda_pkg::ST_FIN;
                    end
                end
                mda_pkg::ST_FIN: begin
                    stateReg <= mda_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // hub master and cpu grant; the two never own the hub together
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hubCycReg <= 1'b0;
            hubWeReg <= 1'b0;
            hubAddrReg <= 16'h0000;
            hubWdataReg <= 8'h00;
            cpuGntReg <= 1'b0;
            starveReg <= 3'h0;
        end else begin
            cpuGntReg <= cpuWin;
            hubCycReg <= hubStart | (hubCycReg & ~hubAck);
            if (hubStart) begin
                hubWeReg <= stateReg == mda_pkg::ST_WRITE;
                hubAddrReg <= (stateReg == mda_pkg::ST_WRITE) ? curDst : curSrc;
                hubWdataReg <= dataReg;
                starveReg <= 3'h0;
            end else if (dmaWants && cpuWin) begin
                starveReg <= 3'(starveReg + 3'h1);
            end
        end
    end

    // channel status, completion and interrupt pulses
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            busyReg <= 24'h0;
            needLoadReg <= 24'h0;
            cancelPendReg <= 24'h0;
            chIntAReg <= 24'h0;
            chIntBReg <= 24'h0;
            donePReg <= 1'b0;
            doneChReg <= 5'h00;
        end else begin
            busyReg <= busyNext;
            needLoadReg <= (needLoadReg | newStart | chainMask) & ~loadMask;
            cancelPendReg <= (cancelPendReg | cancelW) & curMask;
            chIntAReg <= (atFin && w1[mda_pkg::TD_INTEACH]) ?
                finMask : 24'h0;
            chIntBReg <= (finDone && w1[mda_pkg::TD_INTEND]) ?
                finMask : 24'h0;
            donePReg <= finDone;
            doneChReg <= curChReg;
        end
    end

    // per-channel context; the next descriptor may be itself or any other
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 24; i++) begin
            if (newStart[i]) begin
                chTdReg[i] <= chCfgReg[i][mda_pkg::CFG_FIRST +: 7];
            end
        end
        if (stateReg == mda_pkg::ST_LOAD) begin
            chSrcReg[curChReg] <= w0[mda_pkg::TD_SRC +: 16];
            chDstReg[curChReg] <= w0[mda_pkg::TD_DST +: 16];
            chCntReg[curChReg] <= w1[mda_pkg::TD_CNT +: 16];
        end else if (finDone && hasNext) begin
            chTdReg[curChReg] <= w1[mda_pkg::TD_NEXT +: 7];
        end else if (atFin && !lastBeat) begin
            if (!w1[mda_pkg::TD_INF]) begin
                chCntReg[curChReg] <= 16'(curCnt - 16'h0001);
            end
            chSrcReg[curChReg] <= 16'(curSrc +
                {15'h0, w1[mda_pkg::TD_SRCINC]});
            chDstReg[curChReg] <= 16'(curDst +
                {15'h0, w1[mda_pkg::TD_DSTINC]});
        end
    end

    // outputs straight from flip-flops
    assign wb_ack_o = wbAckReg;
    assign wb_dat_o = wbDatReg;
    assign cpuGnt = cpuGntReg;
    assign hubCyc = hubCycReg;
    assign hubWe = hubWeReg;
    assign hubAddr = hubAddrReg;
    assign hubWdata = hubWdataReg;
    assign chIntA = chIntAReg;
    assign chIntB = chIntBReg;

    // helper view of the requesting levels for the checks below
    logic [7:0] lvlHit;
    logic fixHit;
    always_comb begin
        lvlHit = 8'h00;
        fixHit = 1'b0;
        for (int i = 0; i < 24; i++) begin
            if (reqMask[i]) begin
                lvlHit[prioV[i]] = 1'b1;
                if (prioV[i] == pickLvl && rrDisV[i]) begin
                    fixHit = 1'b1;
                end
            end
        end
    end
    wire higherReq = |(lvlHit & 8'((8'h01 << pickLvl) - 8'h01));
    wire lvl01Req = lvlHit[0] | lvlHit[1];
    wire favHit = lvlHit[favLvl(slotReg)];

    property p_cpu_first;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(hubCycReg) |->
            (!$past(cpuReq) || $past(starveReg) == mda_pkg::STARVE_LIM);
    endproperty
    a_cpu_first: assert property (p_cpu_first)
        else $error("dma took the hub while the cpu had priority");

    property p_no_starve;
        @(posedge sys_clk) disable iff (sys_rst)
        (stateReg == mda_pkg::ST_READ && !hubCycReg) |-> ##[1:8] hubCycReg;
    endproperty
    a_no_starve: assert property (p_no_starve)
        else $error("dma read not started within bound");

    property p_hold_ch;
        @(posedge sys_clk) disable iff (sys_rst)
        (stateReg != mda_pkg::ST_IDLE) |=> (curChReg == $past(curChReg));
    endproperty
    a_hold_ch: assert property (p_hold_ch)
        else $error("channel switched inside a transaction");

    property p_prio_only;
        @(posedge sys_clk) disable iff (sys_rst)
        (grantFire && !fairEnReg) |-> !higherReq;
    endproperty
    a_prio_only: assert property (p_prio_only)
        else $error("grant skipped a higher level without fairness");

    property p_lvl01;
        @(posedge sys_clk) disable iff (sys_rst)
        (grantFire && lvl01Req) |-> (pickLvl <= 3'h1 && !higherReq);
    endproperty
    a_lvl01: assert property (p_lvl01)
        else $error("level 0 or 1 requester lost to fairness");

    property p_fair;
        @(posedge sys_clk) disable iff (sys_rst)
        (grantFire && fairEnReg && !lvl01Req && favHit) |->
            (pickLvl == favLvl(slotReg));
    endproperty
    a_fair: assert property (p_fair)
        else $error("favoured fairness level not granted");

    property p_rr_fix;
        @(posedge sys_clk) disable iff (sys_rst)
        (grantFire && fixHit) |-> rrDisV[pickCh];
    endproperty
    a_rr_fix: assert property (p_rr_fix)
        else $error("fixed-position channel did not lead its level");

    property p_stall;
        @(posedge sys_clk) disable iff (sys_rst)
        grantFire |-> !stallReg[pickCh];
    endproperty
    a_stall: assert property (p_stall)
        else $error("stalled channel was granted");

    property p_int_pulse;
        @(posedge sys_clk) disable iff (sys_rst)
        (|chIntBReg) |=> (chIntBReg == 24'h0) ##1 (chIntBReg == 24'h0);
    endproperty
    a_int_pulse: assert property (p_int_pulse)
        else $error("completion interrupt longer than one pulse");

    property p_chain;
        @(posedge sys_clk) disable iff (sys_rst)
        (finDone && hasNext) |=>
            (needLoadReg[curChReg] && busyReg[curChReg] && donePReg);
    endproperty
    a_chain: assert property (p_chain)
        else $error("chained descriptor not queued for load");

    property p_gnt_excl;
        @(posedge sys_clk) disable iff (sys_rst)
        !(cpuGntReg && hubCycReg);
    endproperty
    a_gnt_excl: assert property (p_gnt_excl)
        else $error("cpu and dma both own the hub");

    c_fair_grant: cover property (@(posedge sys_clk)
        grantFire && fairEnReg && pickLvl > 3'h2);
    c_preempt: cover property (@(posedge sys_clk)
        $rose(grantFire) && pickCh != curChReg);
    c_nested: cover property (@(posedge sys_clk) tdDmaWr);
    c_starve: cover property (@(posedge sys_clk)
        starveReg == mda_pkg::STARVE_LIM && cpuReq);
endmodule

// ==== test/mda_hub_mem.sv ====
`timescale 1ns/100ps
// hub slave: 256 byte memory answering after a chosen wait
module mda_hub_mem (
    // clock
    input wire logic sys_clk,
    // hub port
    input wire logic hubCyc,
    input wire logic hubWe,
    input wire logic [15:0] hubAddr,
    input wire logic [7:0] hubWdata,
    output logic [7:0] hubRdata,
    output logic hubAck,
    // idle cycles before each ack
    input wire logic [1:0] waitCyc
);
    logic [7:0] mem [0:255];
    logic [1:0] cnt = 2'h0;
    // known pattern so a moved byte can be told from a stale one
    initial begin
        hubAck = 1'b0;
        hubRdata = 8'h00;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    end
    // rdata flips outside the ack so a late sample sees inverted data
    always @(posedge sys_clk) begin
        if (hubCyc && !hubAck && cnt == waitCyc) begin
            hubAck <= 1'b1;
            cnt <= 2'h0;
            if (hubWe) mem[hubAddr[7:0]] <= hubWdata;
            else hubRdata <= mem[hubAddr[7:0]];
        end else begin
            hubAck <= 1'b0;
            hubRdata <= ~hubRdata;
            if (hubCyc && !hubAck) cnt <= cnt + 2'h1;
        end
    end
endmodule

// ==== test/mda_core_bench.sv ====
`timescale 1ns/100ps
// table of single descriptor moves, then stall, cpu and reset cases
module mda_core_bench;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] wbAdr = 12'h000;
    logic [31:0] wbDat = 32'h0, rd, wbDatO;
    logic wbWe = 1'b0, wbReq = 1'b0, cpuReq = 1'b0;
    logic [23:0] dmaReq = 24'h0, intA, intB;
    logic [1:0] waitCyc = 2'h0;
    logic wbAck, cpuGnt, hubCyc, hubWe, hubAck;
    logic [15:0] hubAddr;
    logic [7:0] hubWdata, hubRdata;
    int err_total = 0, checks_done = 0;
    typedef struct {int ch; int src; int dst; int cnt; int wt;} mda_row_t;
    mda_row_t rows [3] = '{'{0, 16, 64, 0, 0}, '{5, 32, 96, 3, 2},
        '{23, 48, 128, 2, 1}};
    always #25 sys_clk = ~sys_clk;
    mda_core i_mda_core (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .wb_adr_i(wbAdr), .wb_dat_i(wbDat), .wb_sel_i(4'hf),
        .wb_we_i(wbWe), .wb_cyc_i(wbReq), .wb_stb_i(wbReq),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .dmaReq(dmaReq),
        .cpuReq(cpuReq), .cpuGnt(cpuGnt), .hubCyc(hubCyc), .hubWe(hubWe),
        .hubAddr(hubAddr), .hubWdata(hubWdata), .hubRdata(hubRdata),
        .hubAck(hubAck), .chIntA(intA), .chIntB(intB));
    mda_hub_mem i_mda_hub_mem (.sys_clk(sys_clk), .hubCyc(hubCyc),
        .hubWe(hubWe), .hubAddr(hubAddr), .hubWdata(hubWdata),
        .hubRdata(hubRdata), .hubAck(hubAck), .waitCyc(waitCyc));
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // classic cycle: hold until ack, then one idle cycle
    task automatic wb(input logic we, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wbReq <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDat <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        q = wbDatO;
        wbReq <= 1'b0;
        if (n == 50) begin
            err_total++;
            final_report();
        end
        @(posedge sys_clk);
    endtask
    // bounded wait for the completion pulse of one channel
    task automatic wait_end(input int ch);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (intB[ch] !== 1'b1 && n < 500);
        if (n == 500) begin
            err_total++;
            final_report();
        end
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        chk("ctl outs in reset", 32'h0, {29'h0, wbAck, cpuGnt, hubCyc});
        chk("int a in reset", 32'h0, {8'h0, intA});
        chk("int b in reset", 32'h0, {8'h0, intB});
        @(posedge sys_clk);
        wb(1'b0, mda_pkg::REG_BUSY, 32'h0, rd);
        chk("busy after reset", 32'h0, rd);
        wb(1'b0, 12'h020, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        // each row: priority k, descriptor k, increments, completion pulse
        foreach (rows[k]) begin
            waitCyc <= rows[k].wt[1:0];
            wb(1'b1, 12'h080 + 12'(4 * rows[k].ch), 32'h800 | (k << 4) | k,
                rd);
            wb(1'b1, 12'h400 + 12'(8 * k), (rows[k].dst << 16) | rows[k].src,
                rd);
            wb(1'b1, 12'h404 + 12'(8 * k), 32'h16000000 | rows[k].cnt,
                rd);
            wb(1'b1, mda_pkg::REG_SWTRIG, 32'h1 << rows[k].ch, rd);
            wait_end(rows[k].ch);
            for (int i = 0; i <= rows[k].cnt; i++)
                chk("moved byte", 32'(8'(rows[k].src + i) ^ 8'h5a),
                    32'(i_mda_hub_mem.mem[rows[k].dst + i]));
            wb(1'b0, mda_pkg::REG_BUSY, 32'h0, rd);
            chk("busy after end", 32'h0, rd);
        end
        // stalled channel started by its request line holds off the hub
        wb(1'b1, 12'h400, 32'h00a00010, rd);
        wb(1'b1, mda_pkg::REG_STALL, 32'h1, rd);
        dmaReq <= 24'h1;
        @(posedge sys_clk);
        dmaReq <= 24'h0;
        repeat (20) @(posedge sys_clk);
        chk("held dest", 32'h000000fa, 32'(i_mda_hub_mem.mem[160]));
        wb(1'b1, mda_pkg::REG_STALL, 32'h0, rd);
        wait_end(0);
        chk("resumed dest", 32'h0000004a, 32'(i_mda_hub_mem.mem[160]));
        // cpu holds the hub; a self-linked descriptor still completes twice
        wb(1'b1, mda_pkg::REG_CTRL, 32'h1, rd);
        wb(1'b0, mda_pkg::REG_CTRL, 32'h0, rd);
        chk("fair enable", 32'h1, rd);
        wb(1'b1, 12'h080, 32'h802, rd);
        wb(1'b1, 12'h404, 32'h18800001, rd);
        cpuReq <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("cpu grant", 32'h1, 32'(cpuGnt));
        wb(1'b1, mda_pkg::REG_SWTRIG, 32'h1, rd);
        wait_end(0);
        chk("byte pulse", 32'h1, 32'(intA[0]));
        wait_end(0);
        cpuReq <= 1'b0;
        wb(1'b1, mda_pkg::REG_CANCEL, 32'h1, rd);
        repeat (30) @(posedge sys_clk);
        wb(1'b0, mda_pkg::REG_BUSY, 32'h0, rd);
        chk("busy after cancel", 32'h0, rd);
        // reset after the cancel clears fairness and channel configuration
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        wb(1'b0, mda_pkg::REG_CTRL, 32'h0, rd);
        chk("ctrl after reset", 32'h0, rd);
        wb(1'b0, 12'h080, 32'h0, rd);
        chk("cfg after reset", 32'h0, rd);
        final_report();
    end
endmodule
